// File: rtl/e1ta_pkg.sv
package e1ta_pkg;

  // port count and microprocessor address width
  localparam int          NUM_PORTS   = 4;
  localparam int          ADDR_W      = 12;

  // per-port register offsets, port 1 first
  localparam logic [11:0] LATCHED_OFS [NUM_PORTS] = '{12'h044, 12'h074, 12'h0A4, 12'h0D4};
  localparam logic [11:0] LIVE_OFS    [NUM_PORTS] = '{12'h045, 12'h075, 12'h0A5, 12'h0D5};
  localparam logic [11:0] OEI_OFS     [NUM_PORTS] = '{12'h182, 12'h282, 12'h382, 12'h482};
  localparam logic [11:0] V4_OFS      [NUM_PORTS] = '{12'h196, 12'h296, 12'h396, 12'h496};

  // alarm register field positions
  localparam int          RXF_BIT     = 7;
  localparam int          UNUSED_BIT  = 6;
  localparam int          PRBS_BIT    = 5;
  localparam int          ADDA_BIT    = 4;
  localparam int          ADDB_BIT    = 3;
  localparam int          LOS_BIT     = 2;
  localparam int          LOC_BIT     = 1;
  localparam int          AIS_BIT     = 0;
  localparam logic [7:0]  LATCH_MASK  = 8'hBF;   // bits 7 and 5-0 latch

  // error indication in N2 bit 6, where bit 1 is the msb
  localparam int          OEI_BIT_POS = 2;
  localparam logic [7:0]  CNT_MAX     = 8'hFF;

  // reset values
  localparam logic [7:0]  REG_RESET   = 8'h00;

  // loss of clock timing
  localparam int          SYS_CLK_PERIOD_NS  = 100;
  localparam int          LINE_CLK_PERIOD_NS = 800;
  localparam int          LOC_PERIODS        = 6;
  localparam int          LOC_TIME_NS        = LOC_PERIODS * LINE_CLK_PERIOD_NS;
  localparam logic [5:0]  LOC_CYCLES         =
    6'((LOC_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

  // loss of signal and line ais counts, in pulse positions
  localparam logic [8:0]  LOS_QUIET_POS   = 9'h100;
  localparam logic [7:0]  WINDOW_LAST     = 8'hFF;   // 256 positions per window
  localparam logic [5:0]  LOS_RECOV_TRANS = 6'h20;
  localparam logic [1:0]  AIS_SET_ZEROS   = 2'h1;
  localparam logic [1:0]  AIS_CLR_ZEROS   = 2'h3;

  // add bus fifo hold, in multiframes
  localparam logic [1:0]  ADD_HOLD_MF     = 2'h2;

  // all block state
  typedef struct packed {
    logic [NUM_PORTS-1:0][2:0] clk_sy;    // line clock synchroniser
    logic [NUM_PORTS-1:0][2:0] pos_sy;    // positive rail synchroniser
    logic [NUM_PORTS-1:0][2:0] neg_sy;    // negative rail / ext los synchroniser
    logic [NUM_PORTS-1:0][5:0] loc_cnt;   // cycles since last clock edge
    logic [NUM_PORTS-1:0]      loc;       // loss of clock
    logic [NUM_PORTS-1:0]      last_pos;  // rail at previous position
    logic [NUM_PORTS-1:0]      last_neg;
    logic [NUM_PORTS-1:0][8:0] quiet;     // positions without transition
    logic [NUM_PORTS-1:0][7:0] win;       // position in los window
    logic [NUM_PORTS-1:0][5:0] trans;     // transitions in window
    logic [NUM_PORTS-1:0]      los_rail;  // rail-mode loss of signal
    logic [NUM_PORTS-1:0][7:0] ais_pos;   // position in ais block
    logic [NUM_PORTS-1:0][1:0] zeros;     // zeros in ais block, saturating
    logic [NUM_PORTS-1:0]      ais;       // line ais detected
    logic [NUM_PORTS-1:0]      rxf;       // receive fifo error
    logic [NUM_PORTS-1:0]      a_hold;    // add bus a fifo held
    logic [NUM_PORTS-1:0][1:0] a_mf;
    logic [NUM_PORTS-1:0]      b_hold;    // add bus b fifo held
    logic [NUM_PORTS-1:0][1:0] b_mf;
    logic [NUM_PORTS-1:0][7:0] latched;   // latched alarms
    logic [NUM_PORTS-1:0][7:0] outgoing_error_indication;       // outgoing error count
    logic [NUM_PORTS-1:0][7:0] v4;        // captured spare overhead byte
    logic [7:0]                rdata;     // read data
    logic                      rvalid;    // read answer strobe
  } e1ta_state_t;

endpackage

// File: rtl/e1ta_alarm_status.sv
`timescale 1ns/1ps
module e1ta_alarm_status
  import e1ta_pkg::*;
(
  input  wire logic                                   sys_clk,             // system clock
  input  wire logic                                   sys_rst,             // sync reset
  input  wire logic                                   ce,                  // clock enable
  input  wire logic [e1ta_pkg::ADDR_W-1:0]            up_addr,             // read address
  input  wire logic                                   up_rd,               // read strobe
  output logic [7:0]                                  up_rdata,            // read data
  output logic                                        up_rvalid,           // read answer
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0]         tc_enable,           // tandem feature on
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0]         spare_overhead_capture_enable, // v4 on
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0]         nrz_mode,            // 1 nrz, 0 rails
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0]         n2_valid,            // n2 byte strobe
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0][7:0]    n2_data,             // n2 byte
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0]         v4_valid,            // v4 byte strobe
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0][7:0]    v4_data,             // v4 byte
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0]         rx_fifo_fault,       // rx fifo over/under
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0]         prbs_locked,         // analyzer in lock
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0]         add_a_fault,         // add fifo a over/under
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0]         add_b_fault,         // add fifo b over/under
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0]         multiframe_tick,     // multiframe start
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0]         transmit_line_clock, // line clock pin
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0]         positive_rail_input, // rail / nrz data pin
  input  wire logic [e1ta_pkg::NUM_PORTS-1:0]         negative_rail_input, // rail / ext los_n pin
  output logic [e1ta_pkg::NUM_PORTS-1:0]              rx_fifo_reset,       // rx fifo reset pulse
  output logic [e1ta_pkg::NUM_PORTS-1:0]              add_a_fifo_reset,    // add fifo a held
  output logic [e1ta_pkg::NUM_PORTS-1:0]              add_b_fifo_reset,    // add fifo b held
  output logic [e1ta_pkg::NUM_PORTS-1:0]              add_ais_insert       // send ais on add bus
);
  import e1ta_pkg::*;

  e1ta_state_t st;       // registered state
  e1ta_state_t next_st;  // next state

  // saturating byte increment
  function automatic logic [7:0] sat_inc8(input logic [7:0] v);
    sat_inc8 = (v == CNT_MAX) ? v : v + 8'h01;
  endfunction

  // add fifo hold sequencer: {hold, mf}
  function automatic logic [2:0] hold_step(input logic fault, input logic tick,
                                           input logic hold, input logic [1:0] mf);
    hold_step = {hold, mf};
    if (fault)
    begin
      hold_step = {1'b1, 2'h0};  // new error restarts the hold
    end
    else if (hold && tick)
    begin
      if (mf + 2'h1 == ADD_HOLD_MF)
      begin
        hold_step = {1'b0, 2'h0};
      end
      else
      begin
        hold_step = {1'b1, 2'(mf + 2'h1)};
      end
    end
  endfunction

  // live alarm byte of one port, bit 6 fixed at zero
  function automatic logic [7:0] live_of(input e1ta_state_t s, input int p,
                                         input logic locked, input logic nrz);
    live_of = 8'h00;
    live_of[RXF_BIT]  = s.rxf[p];
    live_of[PRBS_BIT] = ~locked;
    live_of[ADDA_BIT] = s.a_hold[p];
    live_of[ADDB_BIT] = s.b_hold[p];
    live_of[LOS_BIT]  = nrz ? ~s.neg_sy[p][1] : s.los_rail[p];
    live_of[LOC_BIT]  = s.loc[p];
    live_of[AIS_BIT]  = s.ais[p];
  endfunction

  // next state of all ports and the read port
  always_comb
  begin
    logic       edge_seen;
    logic       rise;
    logic       trans_now;
    logic       bit_now;
    logic [1:0] zeros_nx;
    logic [5:0] trans_nx;
    logic [7:0] base;
    logic [7:0] live;
    logic [2:0] hs;
    edge_seen = 1'b0;
    rise      = 1'b0;
    trans_now = 1'b0;
    bit_now   = 1'b0;
    zeros_nx  = 2'h0;
    trans_nx  = 6'h00;
    base      = 8'h00;
    live      = 8'h00;
    hs        = 3'h0;
    next_st        = st;
    next_st.rvalid = 1'b0;
    if (up_rd)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = 8'h00;  // unmapped addresses read zero
    end
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      // pins pass two flops; third stage only for edge finding
      next_st.clk_sy[p] = {st.clk_sy[p][1:0], transmit_line_clock[p]};
      next_st.pos_sy[p] = {st.pos_sy[p][1:0], positive_rail_input[p]};
      next_st.neg_sy[p] = {st.neg_sy[p][1:0], negative_rail_input[p]};
      edge_seen = st.clk_sy[p][1] ^ st.clk_sy[p][2];
      rise      = st.clk_sy[p][1] & ~st.clk_sy[p][2];

      // loss of clock from cycles since last edge
      if (edge_seen)
      begin
        next_st.loc_cnt[p] = 6'h00;
        next_st.loc[p]     = 1'b0;
      end
      else if (st.loc_cnt[p] == LOC_CYCLES)
      begin
        next_st.loc[p] = 1'b1;
      end
      else
      begin
        next_st.loc_cnt[p] = st.loc_cnt[p] + 6'h01;
      end

      // one pulse position per rising line clock edge
      if (rise)
      begin
        trans_now = (st.pos_sy[p][1] != st.last_pos[p]) | (st.neg_sy[p][1] != st.last_neg[p]);
        next_st.last_pos[p] = st.pos_sy[p][1];
        next_st.last_neg[p] = st.neg_sy[p][1];
        // rail-mode loss of signal: window recovery, then quiet detect
        trans_nx = (trans_now && st.trans[p] != LOS_RECOV_TRANS) ?
                   st.trans[p] + 6'h01 : st.trans[p];
        next_st.win[p]   = st.win[p] + 8'h01;
        next_st.trans[p] = trans_nx;
        if (st.win[p] == WINDOW_LAST)
        begin
          next_st.trans[p] = 6'h00;
          if (trans_nx == LOS_RECOV_TRANS)
          begin
            next_st.los_rail[p] = 1'b0;
          end
        end
        if (trans_now)
        begin
          next_st.quiet[p] = 9'h000;
        end
        else if (st.quiet[p] != LOS_QUIET_POS)
        begin
          next_st.quiet[p] = st.quiet[p] + 9'h001;
          if (st.quiet[p] + 9'h001 == LOS_QUIET_POS)
          begin
            next_st.los_rail[p] = 1'b1;
          end
        end
        // line ais: zeros per 256-bit block; flag only, no data path effect
        bit_now  = nrz_mode[p] ? st.pos_sy[p][1] : (st.pos_sy[p][1] | st.neg_sy[p][1]);
        zeros_nx = (!bit_now && st.zeros[p] != AIS_CLR_ZEROS) ?
                   st.zeros[p] + 2'h1 : st.zeros[p];
        next_st.ais_pos[p] = st.ais_pos[p] + 8'h01;
        next_st.zeros[p]   = zeros_nx;
        if (st.ais_pos[p] == WINDOW_LAST)
        begin
          next_st.zeros[p] = 2'h0;
          if (zeros_nx <= AIS_SET_ZEROS)
          begin
            next_st.ais[p] = 1'b1;
          end
          else if (zeros_nx == AIS_CLR_ZEROS)
          begin
            next_st.ais[p] = 1'b0;
          end
        end
      end

      // receive fifo error doubles as its reset pulse
      next_st.rxf[p] = rx_fifo_fault[p];

      // add bus fifos held for up to two multiframes
      hs = hold_step(add_a_fault[p], multiframe_tick[p], st.a_hold[p], st.a_mf[p]);
      next_st.a_hold[p] = hs[2];
      next_st.a_mf[p]   = hs[1:0];
      hs = hold_step(add_b_fault[p], multiframe_tick[p], st.b_hold[p], st.b_mf[p]);
      next_st.b_hold[p] = hs[2];
      next_st.b_mf[p]   = hs[1:0];

      // error count; a hit during a clearing read counts as one
      base = (up_rd && up_addr == OEI_OFS[p]) ? 8'h00 : st.outgoing_error_indication[p];
      if (tc_enable[p] && n2_valid[p] && n2_data[p][OEI_BIT_POS])
      begin
        base = sat_inc8(base);
      end
      next_st.outgoing_error_indication[p] = base;

      // spare overhead byte stored as received, first bit in bit 7
      if (spare_overhead_capture_enable[p] && v4_valid[p])
      begin
        next_st.v4[p] = v4_data[p];
      end

      // latched alarms: set wins over the clear of a read
      live = live_of(st, p, prbs_locked[p], nrz_mode[p]);
      base = (up_rd && up_addr == LATCHED_OFS[p]) ? 8'h00 : st.latched[p];
      next_st.latched[p] = base | (live & LATCH_MASK);

      // read mux
      if (up_rd)
      begin
        if (up_addr == LATCHED_OFS[p])
        begin
          next_st.rdata = st.latched[p] & LATCH_MASK;
        end
        else if (up_addr == LIVE_OFS[p])
        begin
          next_st.rdata = live;
        end
        else if (up_addr == OEI_OFS[p])
        begin
          next_st.rdata = st.outgoing_error_indication[p];
        end
        else if (up_addr == V4_OFS[p])
        begin
          next_st.rdata = st.v4[p];
        end
      end
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign up_rdata         = st.rdata;
  assign up_rvalid        = st.rvalid;
  assign rx_fifo_reset    = st.rxf;
  assign add_a_fifo_reset = st.a_hold;
  assign add_b_fifo_reset = st.b_hold;
  assign add_ais_insert   = st.a_hold | st.b_hold;

  // checks on port 1; all of them rest while ce is low
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst || !ce);

  // helper: count of a started add hold
  logic [1:0] hold_ticks;  // multiframe ticks seen while held
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || add_a_fault[0] || !st.a_hold[0])
    begin
      hold_ticks <= 2'h0;
    end
    else if (ce && multiframe_tick[0] && hold_ticks != 2'h3)
    begin
      hold_ticks <= hold_ticks + 2'h1;
    end
  end

  a_oei_count_up: assert property (
    (tc_enable[0] && n2_valid[0] && n2_data[0][OEI_BIT_POS] && !up_rd && st.outgoing_error_indication[0] != CNT_MAX)
      |=> st.outgoing_error_indication[0] == $past(st.outgoing_error_indication[0]) + 8'h01)
    else $error("error count did not step");
  a_oei_saturates: assert property (
    (st.outgoing_error_indication[0] == CNT_MAX && !up_rd) |=> st.outgoing_error_indication[0] == CNT_MAX)
    else $error("error count wrapped");
  a_oei_read_clear: assert property (
    (up_rd && up_addr == OEI_OFS[0] && !(n2_valid[0] && tc_enable[0]))
      |=> st.outgoing_error_indication[0] == 8'h00 ##0 up_rvalid && up_rdata == $past(st.outgoing_error_indication[0]))
    else $error("error count read did not clear");
  a_v4_capture: assert property (
    (spare_overhead_capture_enable[0] && v4_valid[0]) |=> st.v4[0] == $past(v4_data[0]))
    else $error("spare byte not captured");
  a_latch_holds: assert property (
    (st.latched[0][LOC_BIT] && !(up_rd && up_addr == LATCHED_OFS[0]))
      |=> st.latched[0][LOC_BIT])
    else $error("latched alarm dropped without read");
  a_bit6_zero: assert property (
    up_rvalid && ($past(up_addr) == LIVE_OFS[0] || $past(up_addr) == LATCHED_OFS[0])
      |-> !up_rdata[UNUSED_BIT])
    else $error("alarm bit 6 read as one");
  a_rx_reset: assert property (
    rx_fifo_fault[0] |=> rx_fifo_reset[0] ##1 st.latched[0][RXF_BIT])
    else $error("rx fifo error not flagged");
  a_add_hold: assert property (
    add_a_fault[0] |=> add_a_fifo_reset[0] && add_ais_insert[0])
    else $error("add fifo not held with ais");
  a_hold_bound: assert property (
    hold_ticks <= ADD_HOLD_MF)
    else $error("add fifo held past two multiframes");
  a_loc_raise: assert property (
    (st.loc_cnt[0] == LOC_CYCLES && !(st.clk_sy[0][1] ^ st.clk_sy[0][2])) |=> st.loc[0])
    else $error("loss of clock not raised");
  a_loc_clear: assert property (
    (st.loc[0] && (st.clk_sy[0][1] ^ st.clk_sy[0][2])) |=> !st.loc[0])
    else $error("loss of clock not cleared on edge");
  a_nrz_los: assert property (
    (nrz_mode[0] && up_rd && up_addr == LIVE_OFS[0])
      |=> up_rdata[LOS_BIT] == !$past(st.neg_sy[0][1]))
    else $error("nrz loss of signal not following pin");
  a_los_raise: assert property (
    (st.clk_sy[0][1] && !st.clk_sy[0][2] && st.quiet[0] == LOS_QUIET_POS - 9'h001
      && st.pos_sy[0][1] == st.last_pos[0] && st.neg_sy[0][1] == st.last_neg[0])
      |=> st.los_rail[0])
    else $error("rail loss of signal not raised");
  a_ais_raise: assert property (
    (st.clk_sy[0][1] && !st.clk_sy[0][2] && st.ais_pos[0] == WINDOW_LAST
      && st.zeros[0] == 2'h0)
      |=> st.ais[0])
    else $error("line ais not raised");

  c_loc_event: cover property (st.loc[0] ##[1:200] !st.loc[0]);
  c_oei_sat: cover property (st.outgoing_error_indication[0] == CNT_MAX);
  c_ais_seen: cover property (st.ais[0]);
  c_los_rail: cover property (st.los_rail[0] ##[1:1000] !st.los_rail[0]);

endmodule // e1ta_alarm_status

// File: testbench/e1ta_line_model.sv
`timescale 1ns/1ps
// far-side e1 line source; its clock stands still unless run is high
module e1ta_line_model
(
  input  wire logic run,       // line clock running
  input  wire logic pat,       // 0 all marks, 1 alternating
  input  wire logic nrz,       // nrz line format
  input  wire logic los_n,     // external loss indication, low = loss
  output logic      line_clk,  // transmit line clock
  output logic      pos,       // positive rail or nrz data
  output logic      neg        // negative rail or loss pin
);
  // phase unrelated to the system clock, 800 ns period
  initial
  begin
    line_clk = 1'b0;
    pos      = 1'b0;
    #137;
    forever
    begin
      if (run)
      begin
        #400 line_clk = 1'b1;
        #400 line_clk = 1'b0;
        // data moves on the falling edge, far from the sampling edge
        pos = pat ? ~pos : 1'b1;
      end
      else
        #100;
    end
  end

  // in nrz the negative pin carries the active-low loss lead
  assign neg = nrz ? los_n : 1'b0;
endmodule // e1ta_line_model

// File: testbench/test_e1_tributary_alarm_status.sv
`timescale 1ns/1ps
// self-checking bench; port 1 is exercised, the line feeds all ports
module test_e1_tributary_alarm_status;
  import e1ta_pkg::*;
  // stimulus, named after the ports
  logic                      sys_clk, sys_rst, ce, up_rd;
  logic [ADDR_W-1:0]         up_addr;
  logic [NUM_PORTS-1:0]      tc_enable, spare_overhead_capture_enable, nrz_mode;
  logic [NUM_PORTS-1:0]      n2_valid, v4_valid, rx_fifo_fault, prbs_locked;
  logic [NUM_PORTS-1:0]      add_a_fault, add_b_fault, multiframe_tick;
  logic [NUM_PORTS-1:0][7:0] n2_data, v4_data;
  // answers
  logic [7:0]                up_rdata, rd;
  logic                      up_rvalid;
  logic [NUM_PORTS-1:0]      rx_fifo_reset, add_a_fifo_reset, add_b_fifo_reset, add_ais_insert;
  // line model controls and pins
  logic                      run, pat, los_n, lclk, pos, neg;
  int                        n_mismatch, n_checks;

  e1ta_alarm_status e1ta_alarm_status_inst
  (
    .sys_clk, .sys_rst, .ce, .up_addr, .up_rd, .up_rdata, .up_rvalid, .tc_enable,
    .spare_overhead_capture_enable, .nrz_mode, .n2_valid, .n2_data, .v4_valid, .v4_data,
    .rx_fifo_fault, .prbs_locked, .add_a_fault, .add_b_fault, .multiframe_tick,
    .transmit_line_clock ({NUM_PORTS{lclk}}),
    .positive_rail_input ({NUM_PORTS{pos}}),
    .negative_rail_input ({NUM_PORTS{neg}}),
    .rx_fifo_reset, .add_a_fifo_reset, .add_b_fifo_reset, .add_ais_insert
  );

  e1ta_line_model e1ta_line_model_inst
  (
    .run(run), .pat(pat), .nrz(nrz_mode[0]), .los_n(los_n), .line_clk(lclk), .pos(pos),
    .neg(neg)
  );

  // 10 mhz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // compare and count
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // one read: strobe for one cycle, answer one cycle later
  task automatic rd_reg(input logic [11:0] a);
    @(negedge sys_clk);
    up_addr = a;
    up_rd   = 1'b1;
    @(negedge sys_clk);
    up_rd = 1'b0;
    rd    = up_rdata;
    chk("read strobe", 8'h01, {7'h00, up_rvalid});
  endtask

  // verdict and end of run
  task automatic test_done;
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // idle map, unused bit, unmapped place
  task automatic t_map;
    rd_reg(12'h7FF);
    chk("unmapped", 8'h00, rd);
    rd_reg(LIVE_OFS[0]);
    chk("live idle", 8'h00, rd);
    rd_reg(LATCHED_OFS[0]);
    chk("latched idle", 8'h00, rd);
  endtask

  // error count: gating, clear on read, saturation
  task automatic t_oei;
    rd_reg(OEI_OFS[0]);
    tc_enable[0] = 1'b1;
    n2_valid[0]  = 1'b1;
    n2_data[0]   = 8'h04;
    cyc(3);
    n2_data[0] = 8'hFB;  // every bit but the error bit
    cyc(1);
    tc_enable[0] = 1'b0;  // disabled: must not count
    n2_data[0]   = 8'h04;
    cyc(1);
    n2_valid[0] = 1'b0;
    rd_reg(OEI_OFS[0]);
    chk("oei count", 8'h03, rd);
    rd_reg(OEI_OFS[0]);
    chk("oei cleared", 8'h00, rd);
    tc_enable[0] = 1'b1;
    n2_valid[0]  = 1'b1;
    cyc(300);
    n2_valid[0] = 1'b0;
    rd_reg(OEI_OFS[0]);
    chk("oei saturate", 8'hFF, rd);
  endtask

  // capture only while enabled, and nothing lands while ce is low
  task automatic t_v4;
    spare_overhead_capture_enable[0] = 1'b1;
    v4_valid[0] = 1'b1;
    v4_data[0]  = 8'hA5;
    cyc(1);
    ce         = 1'b0;  // frozen: this byte must not land
    v4_data[0] = 8'h5A;
    cyc(2);
    ce = 1'b1;
    spare_overhead_capture_enable[0] = 1'b0;
    v4_data[0] = 8'h3C;
    cyc(1);
    v4_valid[0] = 1'b0;
    rd_reg(V4_OFS[0]);
    chk("v4 byte", 8'hA5, rd);
  endtask

  // receive fifo fault: reset pulse, latched then cleared
  task automatic t_rxf;
    rx_fifo_fault[0] = 1'b1;
    cyc(1);
    rx_fifo_fault[0] = 1'b0;
    chk("rx fifo reset", 8'h01, {7'h00, rx_fifo_reset[0]});
    rd_reg(LATCHED_OFS[0]);
    chk("latched rx", 8'h80, rd & 8'hC0);
    rd_reg(LATCHED_OFS[0]);
    chk("latched rx clr", 8'h00, rd & 8'h80);
  endtask

  // analyzer unlock: live level, latch sticks, re-set while active
  task automatic t_prbs;
    prbs_locked[0] = 1'b0;
    cyc(2);
    rd_reg(LIVE_OFS[0]);
    chk("live prbs", 8'h20, rd & 8'h60);
    rd_reg(LATCHED_OFS[0]);
    rd_reg(LATCHED_OFS[0]);
    chk("latched reset", 8'h20, rd & 8'h20);
    prbs_locked[0] = 1'b1;
    cyc(2);
    rd_reg(LIVE_OFS[0]);
    chk("live prbs off", 8'h00, rd & 8'h20);
    rd_reg(LATCHED_OFS[0]);
    chk("latched sticks", 8'h20, rd & 8'h20);
    rd_reg(LATCHED_OFS[0]);
    chk("latched clear", 8'h00, rd & 8'h20);
  endtask

  // add fifo fault: held two multiframes with ais on the add bus
  task automatic t_add(input logic b);
    logic [7:0] which;  // expected {b held, a held}
    which = b ? 8'h02 : 8'h01;
    add_a_fault[0] = ~b;
    add_b_fault[0] = b;
    cyc(1);
    add_a_fault[0] = 1'b0;
    add_b_fault[0] = 1'b0;
    chk("ais insert", 8'h01, {7'h00, add_ais_insert[0]});
    repeat (2)
    begin
      chk("fifo held", which, {6'h00, add_b_fifo_reset[0], add_a_fifo_reset[0]});
      cyc(3);
      multiframe_tick[0] = 1'b1;
      cyc(1);
      multiframe_tick[0] = 1'b0;
      cyc(2);
    end
    chk("fifo freed", 8'h00, {6'h00, add_b_fifo_reset[0], add_a_fifo_reset[0]});
    chk("ais ended", 8'h00, {7'h00, add_ais_insert[0]});
    rd_reg(LATCHED_OFS[0]);
    chk("latched add", b ? 8'h08 : 8'h10, rd & 8'h18);
  endtask

  // line clock stopped, then restarted
  task automatic t_loc;
    run = 1'b0;
    cyc(80);
    rd_reg(LIVE_OFS[0]);
    chk("clock loss", 8'h02, rd & 8'h02);
    run = 1'b1;
    cyc(20);
    rd_reg(LIVE_OFS[0]);
    chk("clock back", 8'h00, rd & 8'h02);
  endtask

  // quiet all-marks line, then busy line, then nrz loss lead
  task automatic t_line;
    pat = 1'b0;
    cyc(5200);
    rd_reg(LIVE_OFS[0]);
    chk("los ais set", 8'h05, rd & 8'h05);
    chk("ais no action", 8'h00, {7'h00, add_ais_insert[0]});
    pat = 1'b1;
    cyc(5200);
    rd_reg(LIVE_OFS[0]);
    chk("los ais clear", 8'h00, rd & 8'h05);
    nrz_mode[0] = 1'b1;
    los_n = 1'b0;
    cyc(10);
    rd_reg(LIVE_OFS[0]);
    chk("nrz los", 8'h04, rd & 8'h04);
    los_n = 1'b1;
    cyc(10);
    rd_reg(LIVE_OFS[0]);
    chk("nrz los off", 8'h00, rd & 8'h04);
  endtask

  // hang guard, about four and a half times the expected run
  initial
  begin
    #5_000_000;
    n_mismatch++;
    test_done;
  end

  // main sequence
  initial
  begin
    n_mismatch = 0;
    n_checks   = 0;
    {sys_rst, ce, up_rd, up_addr} = {1'b1, 1'b1, 1'b0, 12'h000};
    {tc_enable, spare_overhead_capture_enable, nrz_mode} = '0;
    {n2_valid, v4_valid, rx_fifo_fault, add_a_fault, add_b_fault} = '0;
    {multiframe_tick, n2_data, v4_data} = '0;
    prbs_locked = 4'hF;
    {run, pat, los_n} = 3'h7;
    cyc(8);
    sys_rst = 1'b0;
    cyc(20);
    t_map;
    t_oei;
    t_v4;
    t_rxf;
    t_prbs;
    t_add(1'b0);
    t_add(1'b1);
    t_loc;
    t_line;
    test_done;
  end
endmodule // test_e1_tributary_alarm_status
